/* hw/rips_top.sv */
// Receiver input port: capture, exponent scaling, seven-sample delay, AXI4-Lite registers
// How it works
// [R1] Mantissa, exponent, select captured together each edge
// [R2] Mode register picks real, diversity or complex
// [R3] Mantissa handled as signed twos complement
// [R4] Exponent handled as unsigned zero to seven
// [R5] Scale register holds offset and invert bit
// [R6] Normal: shift by (exp plus offset) mod 8
// [R7] Inverted: shift by (7 minus exp plus offset)
// [R8] Fixed-point converter: exponent low, controls zero
// [R9] Narrow converters drive mantissa MSB-justified
// [R10] Scaled value passed on without overflow guard
// [R11] Sample rate integer fraction of clock
// [R12] Complex mode: select tells I from Q
// [R13] Real mode: select high enables capture
// [R14] Diversity/complex: first sample after select change
// [R15] Complex: Q paired with preceding I
// [R16] Soft reset: seven accepted samples before output
// [R17] Scaling is arithmetic right shift, fraction kept
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "rips_defs.svh"
`default_nettype none
module rips_top #(
   parameter int DEPTH = `RIPS_FIFO_DEPTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   // Converter pins
   input wire logic [`RIPS_MANT_W-1:0] adc_mantissa,
   input wire logic [`RIPS_EXP_W-1:0] adc_exponent,
   input wire logic adc_chan_sel,
   // Scaled samples toward the NCO
   output logic nco_valid,
   input wire logic nco_ready,
   output logic nco_chan_a,
   output logic [`RIPS_DATA_W-1:0] nco_first,
   output logic [`RIPS_DATA_W-1:0] nco_second,
   // AXI4-Lite write address
   input wire logic [`RIPS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [`RIPS_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import rips_pkg::*;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------

   // Word index of a byte address
   function automatic logic [9:0] rips_idx(
      input logic [`RIPS_ADDR_W-1:0] addr
   );
      return addr[`RIPS_ADDR_W-1:2];
   endfunction : rips_idx

   // True when an index names a register
   function automatic logic rips_mapped(input logic [9:0] idx);
      return (idx == `RIPS_IDX_MODE) || (idx == `RIPS_IDX_SCALE) ||
         (idx == `RIPS_IDX_CTRL) || (idx == `RIPS_IDX_STAT);
   endfunction : rips_mapped

   // Power-of-two downscaling of one sample
   function automatic logic [`RIPS_DATA_W-1:0] rips_scale(
      input logic [`RIPS_MANT_W-1:0] mant,
      input logic [`RIPS_EXP_W-1:0] expo,
      input logic [7:0] ctl
   );
      logic [`RIPS_EXP_W-1:0] off;
      logic [`RIPS_EXP_W-1:0] sh;
      logic signed [`RIPS_DATA_W-1:0] wide;
      off = ctl[`RIPS_OFF_MSB:`RIPS_OFF_LSB]; // R5
      // Three-bit sums wrap, giving the modulo 8
      if (ctl[`RIPS_INV_BIT]) begin
         sh = `RIPS_EXP_MAX - expo + off; // R7
      end else begin
         sh = expo + off; // R6
      end
      // Fraction bits below the mantissa keep shifted-out bits
      wide = {mant, {`RIPS_FRAC_W{1'b0}}}; // R3
      return wide >>> sh; // R17
   endfunction : rips_scale

   // ----------------------------------------
   // State and combinational signals
   // ----------------------------------------
   rips_state_t r; // Registered state
   rips_state_t n; // Next state
   logic sel_now; // Filtered select seen this cycle
   logic accept; // Sample qualifies for capture
   logic need_push; // Emerging stage must go to the FIFO
   logic step; // Delay line advances
   logic lost; // Sample dropped on a full buffer
   logic [`RIPS_DATA_W-1:0] scaled; // Scaled new sample
   logic [`RIPS_FIFO_W-1:0] push_data; // Word toward FIFO
   logic fifo_ready; // FIFO has room
   logic [`RIPS_FIFO_W-1:0] fifo_out; // FIFO output word
   logic [$clog2(DEPTH):0] fifo_fill; // FIFO occupancy
   logic [9:0] ar_idx; // Read index
   logic [31:0] rd_word; // Read mux result

   // ----------------------------------------
   // Sample buffer toward the NCO
   // ----------------------------------------
   // Full buffer stalls the delay line; lost samples flag overrun
   rips_fifo #(
      .W(`RIPS_FIFO_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_valid(need_push && step),
      .s_ready(fifo_ready),
      .s_data(push_data),
      .m_valid(nco_valid),
      .m_ready(nco_ready),
      .m_data(fifo_out),
      .fill(fifo_fill)
   );
   assign nco_chan_a = fifo_out[`RIPS_FIFO_W-1];
   assign nco_first = fifo_out[2*`RIPS_DATA_W-1:`RIPS_DATA_W];
   assign nco_second = fifo_out[`RIPS_DATA_W-1:0];

   // Bus outputs straight from the state
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   // Read index decoded straight from the bus
   assign ar_idx = rips_idx(s_axi_araddr);

   // ----------------------------------------
   // Read data mux
   // ----------------------------------------
   always_comb begin
      rd_word = '0;
      unique case (ar_idx)
         `RIPS_IDX_MODE: begin
            rd_word[7:0] = r.mode_reg;
         end
         `RIPS_IDX_SCALE: begin
            rd_word[7:0] = r.scale_reg;
         end
         `RIPS_IDX_CTRL: begin
            rd_word[`RIPS_SRST_BIT] = r.srst_reg;
         end
         `RIPS_IDX_STAT: begin
            // Overrun, primed delay line and buffer fill
            rd_word[`RIPS_OVR_BIT] = r.ovr_reg;
            rd_word[`RIPS_PRIMED_BIT] = r.stg_vld[`RIPS_DELAY-1];
            rd_word[`RIPS_FILL_LSB +: `RIPS_FILL_W] = `RIPS_FILL_W'(fifo_fill);
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      n = r;
      // Three-stage capture of all pins together
      n.mant_sync = {r.mant_sync[1:0], adc_mantissa}; // R1
      n.exp_sync = {r.exp_sync[1:0], adc_exponent}; // R1
      n.sel_sync = {r.sel_sync[1:0], adc_chan_sel}; // R1
      // Select change counts once stages two and three agree
      sel_now = (r.sel_sync[1] == r.sel_sync[2]) ? r.sel_sync[2] : r.sel_filt;
      n.sel_filt = sel_now;

      // Qualify the sample by mode
      if (r.mode_reg[1:0] == `RIPS_MODE_REAL) begin
         accept = sel_now; // R13
      end else begin
         // Only the first edge after a select change
         accept = (sel_now != r.sel_filt); // R14
      end

      // Scale the sample leaving the synchroniser
      scaled = rips_scale(r.mant_sync[2], r.exp_sync[2], r.scale_reg); // R4
      // Emerging stage: complex I is only held, not pushed
      need_push = r.stg_vld[`RIPS_DELAY-1];
      push_data = {r.stg_chan[`RIPS_DELAY-1], r.stg_data[`RIPS_DELAY-1],
         {`RIPS_DATA_W{1'b0}}};
      if (r.mode_reg[1:0] == `RIPS_MODE_CPLX) begin
         // Q goes out with the I seen just before it
         need_push = r.stg_vld[`RIPS_DELAY-1] && !r.stg_chan[`RIPS_DELAY-1] &&
            r.held_vld; // R15
         push_data = {1'b1, r.held_i, r.stg_data[`RIPS_DELAY-1]}; // R12
      end
      step = accept && (!need_push || fifo_ready) && !r.srst_reg;

      // Sample lost to back-pressure
      lost = accept && need_push && !fifo_ready && !r.srst_reg;
      if (lost) begin
         n.ovr_reg = 1'b1;
      end

      // Seven-stage delay line advances per accepted sample
      if (step) begin
         n.stg_vld = {r.stg_vld[`RIPS_DELAY-2:0], 1'b1}; // R16
         n.stg_data = {r.stg_data[`RIPS_DELAY-2:0], scaled}; // R10
         n.stg_chan = {r.stg_chan[`RIPS_DELAY-2:0], sel_now};
         // In-phase sample leaving the line is kept for pairing
         if (r.stg_vld[`RIPS_DELAY-1] && r.stg_chan[`RIPS_DELAY-1]) begin
            n.held_i = r.stg_data[`RIPS_DELAY-1]; // R15
            n.held_vld = 1'b1;
         end else if (r.stg_vld[`RIPS_DELAY-1]) begin
            n.held_vld = 1'b0;
         end
      end

      // Soft reset empties the delay line
      if (r.srst_reg) begin
         n.stg_vld = '0; // R16
         n.held_vld = 1'b0;
      end

      // Write channel: address and data in either order
      if (s_axi_awvalid && r.awready) begin
         n.aw_got = 1'b1;
         n.aw_idx = rips_idx(s_axi_awaddr);
      end
      if (s_axi_wvalid && r.wready) begin
         n.w_got = 1'b1;
         n.w_byte = s_axi_wdata[7:0];
         n.w_lane0 = s_axi_wstrb[0];
      end
      unique case (r.wr_st)
         RIPS_WR_COLLECT: begin
            // Both halves held: commit and answer
            if (r.aw_got && r.w_got) begin
               n.aw_got = 1'b0;
               n.w_got = 1'b0;
               n.bvalid = 1'b1;
               n.wr_st = RIPS_WR_RESP;
               n.bresp = rips_mapped(r.aw_idx) ? `RIPS_RESP_OKAY : `RIPS_RESP_SLVERR;
               if (r.w_lane0) begin
                  unique case (r.aw_idx)
                     `RIPS_IDX_MODE: begin
                        n.mode_reg = r.w_byte; // R2
                     end
                     `RIPS_IDX_SCALE: begin
                        n.scale_reg = r.w_byte; // R5
                     end
                     `RIPS_IDX_CTRL: begin
                        n.srst_reg = r.w_byte[`RIPS_SRST_BIT];
                     end
                     `RIPS_IDX_STAT: begin
                        // Write one clears, a new overrun wins
                        if (r.w_byte[`RIPS_OVR_BIT] && !lost) begin
                           n.ovr_reg = 1'b0;
                        end
                     end
                     default: begin
                        n.ovr_reg = n.ovr_reg;
                     end
                  endcase
               end
            end
         end
         RIPS_WR_RESP: begin
            // Hold the response until taken
            if (s_axi_bready) begin
               n.bvalid = 1'b0;
               n.wr_st = RIPS_WR_COLLECT;
            end
         end
         default: begin
            n.wr_st = RIPS_WR_COLLECT;
         end
      endcase
      // Ready only while that half is still missing
      n.awready = (n.wr_st == RIPS_WR_COLLECT) && !n.aw_got;
      n.wready = (n.wr_st == RIPS_WR_COLLECT) && !n.w_got;

      // Read channel
      unique case (r.rd_st)
         RIPS_RD_IDLE: begin
            if (s_axi_arvalid && r.arready) begin
               n.rdata = rd_word;
               n.rresp = rips_mapped(ar_idx) ? `RIPS_RESP_OKAY : `RIPS_RESP_SLVERR;
               n.rvalid = 1'b1;
               n.rd_st = RIPS_RD_RESP;
            end
         end
         RIPS_RD_RESP: begin
            if (s_axi_rready) begin
               n.rvalid = 1'b0;
               n.rd_st = RIPS_RD_IDLE;
            end
         end
         default: begin
            n.rd_st = RIPS_RD_IDLE;
         end
      endcase
      // Ready again once the answer is taken
      n.arready = (n.rd_st == RIPS_RD_IDLE);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Clear, then reset values
         r <= '0;
         r.mode_reg <= `RIPS_MODE_RST;
         r.scale_reg <= `RIPS_SCALE_RST; // R8
         r.wr_st <= RIPS_WR_COLLECT;
         r.rd_st <= RIPS_RD_IDLE;
      end else begin
         r <= n;
      end
   end
endmodule : rips_top
`default_nettype wire

/* hw/rips_defs.svh */
// Constants of the receiver input port scaling block
`ifndef RIPS_DEFS_SVH
`define RIPS_DEFS_SVH
`define RIPS_MANT_W 16
`define RIPS_EXP_W 3
`define RIPS_EXP_MAX 3'h7
`define RIPS_FRAC_W 7
`define RIPS_DATA_W 23
`define RIPS_DELAY 7
`define RIPS_ADDR_W 12
`define RIPS_IDX_MODE 10'h300
`define RIPS_IDX_SCALE 10'h305
`define RIPS_IDX_CTRL 10'h310
`define RIPS_IDX_STAT 10'h311
`define RIPS_MODE_REAL 2'h0
`define RIPS_MODE_DIV 2'h1
`define RIPS_MODE_CPLX 2'h2
`define RIPS_OFF_MSB 7
`define RIPS_OFF_LSB 5
`define RIPS_INV_BIT 4
`define RIPS_SRST_BIT 0
`define RIPS_OVR_BIT 0
`define RIPS_PRIMED_BIT 1
`define RIPS_FILL_LSB 4
`define RIPS_MODE_RST 8'h00
`define RIPS_SCALE_RST 8'h00
`define RIPS_RESP_OKAY 2'h0
`define RIPS_RESP_SLVERR 2'h2
`define RIPS_FIFO_DEPTH 16
`define RIPS_FIFO_W 47
`define RIPS_FILL_W 5
`endif

/* hw/rips_pkg.sv */
// Types of the receiver input port scaling block
`include "rips_defs.svh"
package rips_pkg;
   // Write channel states, one-hot
   typedef enum logic [1:0] {
      RIPS_WR_COLLECT = 2'b01,
      RIPS_WR_RESP = 2'b10
   } rips_wr_t;
   // Read channel states, one-hot
   typedef enum logic [1:0] {
      RIPS_RD_IDLE = 2'b01,
      RIPS_RD_RESP = 2'b10
   } rips_rd_t;
   // Whole state of the top module
   typedef struct packed {
      logic [2:0][`RIPS_MANT_W-1:0] mant_sync;
      logic [2:0][`RIPS_EXP_W-1:0] exp_sync;
      logic [2:0] sel_sync;
      logic sel_filt;
      logic [7:0] mode_reg;
      logic [7:0] scale_reg;
      logic srst_reg;
      logic ovr_reg;
      logic [`RIPS_DELAY-1:0] stg_vld;
      logic [`RIPS_DELAY-1:0][`RIPS_DATA_W-1:0] stg_data;
      logic [`RIPS_DELAY-1:0] stg_chan;
      logic [`RIPS_DATA_W-1:0] held_i;
      logic held_vld;
      rips_wr_t wr_st;
      logic aw_got;
      logic w_got;
      logic [9:0] aw_idx;
      logic [7:0] w_byte;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      rips_rd_t rd_st;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } rips_state_t;
endpackage : rips_pkg

/* hw/rips_fifo.sv */
// Parameterised FIFO with registered output, valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module rips_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [W-1:0] s_data,
   output logic m_valid,
   input wire logic m_ready,
   output logic [W-1:0] m_data,
   output logic [$clog2(DEPTH):0] fill
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem; // Storage words
      logic [PW-1:0] wr; // Write pointer
      logic [PW-1:0] rd; // Read pointer
      logic [PW:0] cnt; // Words held in storage
      logic mv; // Output register full
      logic [W-1:0] md; // Output register
   } rips_fifo_st_t;
   rips_fifo_st_t r;
   rips_fifo_st_t n;
   logic push; // Word taken this cycle
   logic load; // Storage moves to output
   // Honest full: ready only while storage has room
   assign s_ready = (r.cnt != (PW+1)'(DEPTH));
   assign m_valid = r.mv;
   assign m_data = r.md;
   assign fill = r.cnt + {{PW{1'b0}}, r.mv};
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      n = r;
      push = s_valid && s_ready;
      load = (!r.mv || m_ready) && (r.cnt != '0);
      // Consumer took the output word
      if (r.mv && m_ready) begin
         n.mv = 1'b0;
      end
      // Write side, pointer wraps at a power-of-two depth
      if (push) begin
         n.mem[r.wr] = s_data;
         n.wr = r.wr + 1'b1;
      end
      // Refill the output register
      if (load) begin
         n.md = r.mem[r.rd];
         n.mv = 1'b1;
         n.rd = r.rd + 1'b1;
      end
      n.cnt = r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, load};
   end
   // Register the state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule : rips_fifo
`default_nettype wire

/* dv/rips_checker.sv */
// Checker of the output word and register bus handshakes
`timescale 1ns/1ns
`include "rips_defs.svh"
`default_nettype none
module rips_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic nco_valid,
   input wire logic nco_ready,
   input wire logic nco_chan_a,
   input wire logic [`RIPS_DATA_W-1:0] nco_first,
   input wire logic [`RIPS_DATA_W-1:0] nco_second,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------
   // Properties
   // ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Stalled word stays put
   property p_nco_hold;
      nco_valid && !nco_ready |=> nco_valid && $stable({nco_chan_a, nco_first, nco_second});
   endproperty
   a_nco_hold: assert property (p_nco_hold) else $error("output word moved while stalled");
   // Channel B words carry nothing in the second slot
   property p_b_zero;
      nco_valid && !nco_chan_a |-> nco_second == '0;
   endproperty
   a_b_zero: assert property (p_b_zero) else $error("second slot not zero on channel B");
   // Write response held until taken
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   // Read response held until taken
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read response dropped early");
   // Response two edges after address and data
   property p_b_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write response latency wrong");
   // Read data one edge after address
   property p_r_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read response latency wrong");
   // No new write while a response waits
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while response pending");
   // Error reads return zero
   property p_err_zero;
      s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read carries data");
   // Registers are narrow, upper bits read zero
   property p_hi_zero;
      s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
   // Main scenarios
   c_b_word: cover property (nco_valid && nco_ready && !nco_chan_a);
   c_iq_word: cover property (nco_valid && nco_ready && nco_chan_a && nco_second != '0);
   c_stall: cover property (nco_valid && !nco_ready);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : rips_checker
`default_nettype wire

/* dv/rips_adc_model.sv */
// Converter model: mantissa, exponent and select at an integer fraction of the clock
`timescale 1ns/1ns
`default_nettype none
module rips_adc_model (
   input wire logic aclk,
   input wire logic start,
   input wire logic toggle,
   input wire logic fixed,
   input wire logic [3:0] ratio,
   input wire logic [7:0] nsamp,
   output logic busy,
   output logic [15:0] mant,
   output logic [2:0] expo,
   output logic sel
);
   int k;
   int ph;
   // Twelve active bits, MSB-justified, low bits zero
   function automatic logic [15:0] samp_m(input int n);
      return {12'(32'h8a3 + n * 32'h3c7), 4'h0};
   endfunction : samp_m
   initial begin
      busy = 1'b0;
      mant = 16'h0;
      expo = 3'h0;
      sel = 1'b0;
      k = 0;
      ph = 0;
   end
   // One sample every ratio clocks, held in between
   always @(posedge aclk) begin
      if (!busy || k == int'(nsamp)) begin
         // Idle: select low, lines keep changing
         busy <= start && !busy;
         sel <= 1'b0;
         mant <= ~mant;
         expo <= fixed ? 3'h0 : ~expo;
         k = 0;
         ph = 0;
      end else begin
         if (ph == 0) begin
            mant <= samp_m(k);
            expo <= fixed ? 3'h0 : 3'(k);
            sel <= toggle ? ~k[0] : 1'b1;
         end
         ph = ph + 1;
         if (ph == int'(ratio)) begin
            ph = 0;
            k = k + 1;
         end
      end
   end
endmodule : rips_adc_model
`default_nettype wire

/* dv/tb_top.sv */
// Bench of the receiver input port scaling block
`timescale 1ns/1ns
`include "rips_defs.svh"
`default_nettype none
module tb_top;
   logic aclk, aresetn, nco_ready, nco_valid, nco_chan_a;
   logic [`RIPS_DATA_W-1:0] nco_first, nco_second;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] adc_mantissa;
   logic [2:0] adc_exponent;
   logic adc_chan_sel, m_start, m_tog, m_fix, m_busy;
   logic [3:0] m_ratio;
   logic [7:0] m_n;
   logic [46:0] obs[$];
   logic [46:0] expq[$];
   int n_fail, total_checks, cons;
   localparam logic [11:0] A_MODE = {`RIPS_IDX_MODE, 2'h0};
   localparam logic [11:0] A_SCALE = {`RIPS_IDX_SCALE, 2'h0};
   localparam logic [11:0] A_CTRL = {`RIPS_IDX_CTRL, 2'h0};
   localparam logic [11:0] A_STAT = {`RIPS_IDX_STAT, 2'h0};
   rips_top #(.DEPTH(16)) rips_top_inst (.aclk, .aresetn, .adc_mantissa, .adc_exponent, .adc_chan_sel,
      .nco_valid, .nco_ready, .nco_chan_a, .nco_first, .nco_second, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   rips_adc_model adc_inst (.aclk, .start(m_start), .toggle(m_tog), .fixed(m_fix), .ratio(m_ratio),
      .nsamp(m_n), .busy(m_busy), .mant(adc_mantissa), .expo(adc_exponent), .sel(adc_chan_sel));
   // ----------------
   // Tasks
   // ----------------
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   // Compare and count
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] ex);
      total_checks++;
      if (seen !== ex) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, ex, seen);
      end
   endtask : chk
   // Bus write, address and data offered together
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, er);
   endtask : wr
   // Bus read and compare
   task automatic rchk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rresp", s_axi_rresp, er);
      chk("rdata", s_axi_rdata, ed);
   endtask : rchk
   // Expected scaled sample
   function automatic logic [22:0] scl(input int k, input logic [7:0] sc, input logic fx);
      logic [2:0] e, s;
      e = fx ? 3'h0 : 3'(k);
      s = sc[4] ? 3'h7 - e + sc[7:5] : e + sc[7:5];
      return 23'($signed({adc_inst.samp_m(k), 7'h0}) >>> s);
   endfunction : scl
   // One burst: configure, send, collect, compare
   task automatic run_case(input logic [1:0] md, input logic [7:0] sc, input logic tg, input logic fx,
      input logic [3:0] ra, input int n, input int cs);
      int t;
      t = 0;
      wr(A_CTRL, 32'h1, 2'h0);
      wr(A_MODE, {30'h0, md}, 2'h0);
      wr(A_SCALE, {24'h0, sc}, 2'h0);
      wr(A_CTRL, 32'h0, 2'h0);
      obs.delete();
      expq.delete();
      for (int k = 0; k <= n - 8; k++) begin
         if (md != 2'h2) expq.push_back({tg ? ~k[0] : 1'b1, scl(k, sc, fx), 23'h0});
         else if (!k[0] && k < n - 8) expq.push_back({1'b1, scl(k, sc, fx), scl(k + 1, sc, fx)});
      end
      if (cs == 2) expq = expq[0:16];
      cons = cs;
      @(posedge aclk);
      m_tog <= tg;
      m_fix <= fx;
      m_ratio <= ra;
      m_n <= 8'(n);
      m_start <= 1'b1;
      @(posedge aclk);
      m_start <= 1'b0;
      repeat (2) @(posedge aclk);
      while (m_busy && t < 1000) begin
         @(posedge aclk);
         t++;
      end
      repeat (10) @(posedge aclk);
      if (cs == 2) begin
         rchk(A_STAT, 32'h113, 2'h0);
         cons = 0;
      end
      while (obs.size() < expq.size() && t < 3000) begin
         @(posedge aclk);
         t++;
      end
      repeat (20) @(posedge aclk);
      chk("word count", obs.size(), expq.size());
      foreach (expq[i]) chk("nco word", obs[i], expq[i]);
      if (cs == 2) begin
         wr(A_STAT, 32'h1, 2'h0);
         rchk(A_STAT, 32'h002, 2'h0);
      end
   endtask : run_case
   // Consumer: fast, alternating or held off
   always @(posedge aclk) begin
      if (nco_valid && nco_ready) begin
         obs.push_back({nco_chan_a, nco_first, nco_second});
      end
      nco_ready <= (cons == 2) ? 1'b0 : (cons == 1) ? !nco_ready : 1'b1;
   end
   // ----------------
   // Sequence
   // ----------------
   initial begin
      {aresetn, m_start, m_tog, m_fix, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, nco_ready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {n_fail, total_checks, cons} = '0;
      m_ratio = 4'h1;
      m_n = 8'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(A_MODE, 32'h0, 2'h0);
      rchk(A_SCALE, 32'h0, 2'h0);
      wr(A_SCALE, 32'hd0, 2'h0);
      rchk(A_SCALE, 32'hd0, 2'h0);
      wr(12'h0, 32'h1, 2'h2);
      rchk(12'h0, 32'h0, 2'h2);
      run_case(2'h0, 8'h00, 1'b0, 1'b1, 4'h1, 12, 0);
      run_case(2'h0, 8'h60, 1'b0, 1'b0, 4'h1, 15, 1);
      run_case(2'h0, 8'hd0, 1'b0, 1'b0, 4'h1, 15, 0);
      run_case(2'h1, 8'h20, 1'b1, 1'b0, 4'h3, 12, 1);
      run_case(2'h2, 8'h10, 1'b1, 1'b0, 4'h2, 16, 0);
      run_case(2'h0, 8'h00, 1'b0, 1'b0, 4'h1, 27, 2);
      wr(A_CTRL, 32'h1, 2'h0);
      rchk(A_CTRL, 32'h1, 2'h0);
      rchk(A_STAT, 32'h0, 2'h0);
      stop_test();
   end
   // Watchdog against a hang
   initial begin
      repeat (30000) @(posedge aclk);
      n_fail++;
      stop_test();
   end
endmodule : tb_top
bind rips_top rips_checker rips_checker_inst (.aclk, .aresetn, .nco_valid, .nco_ready, .nco_chan_a, .nco_first,
   .nco_second, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
